// ---- rtl/pfs_defs.svh ----
// Constants of the protective fault supervisor
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH
// Register byte offsets
`define PFS_A_CTRL 8'h00
`define PFS_A_INJ 8'h04
`define PFS_A_RSEL 8'h08
`define PFS_A_RCNT 8'h0c
`define PFS_A_RWAIT 8'h10
`define PFS_A_RSUCC 8'h14
`define PFS_A_COAST 8'h18
`define PFS_A_STAT 8'h1c
`define PFS_A_RESET 8'h20
// Control bit positions and reset value
`define PFS_B_GCHK 0
`define PFS_B_OFD 1
`define PFS_B_OPL 2
`define PFS_B_IPL 3
`define PFS_CTRL_RST 4'hc
// Setting values
`define PFS_IDLE_9999 16'h270f
`define PFS_INJ_MIN 16'h0010
`define PFS_INJ_MAX 16'h00fd
`define PFS_RWAIT_RST 16'h000a
`define PFS_RWAIT_MIN 16'h0001
`define PFS_RWAIT_MAX 16'h1770
`define PFS_RSEL_MAX 3'h5
`define PFS_RSEL_ALL 3'h0
`define PFS_RSEL_WIDE 3'h4
`define PFS_RCNT_SUPMAX 8'h0a
`define PFS_RCNT_OUTMIN 8'h65
`define PFS_RCNT_OUTMAX 8'h6e
`define PFS_RCNT_OFS 8'h64
// Fault codes of own detectors, values arbitrary
`define PFS_CODE_NONE 8'h00
`define PFS_CODE_GF 8'h01
`define PFS_CODE_OFD 8'h02
`define PFS_CODE_OPL 8'h03
`define PFS_CODE_IPL 8'h04
`define PFS_CODE_RET 8'h05
// Timing
`define PFS_CLK_HZ 40000000
`define PFS_GCHK_MS 20
`define PFS_IPL_S 1
`define PFS_TENTHS_PER_S 10
`define PFS_SUCC_MULT 4
// Bus answers
`define PFS_RESP_OK 2'b00
`define PFS_RESP_ERR 2'b10
`endif

// ---- rtl/pfs_pkg.sv ----
// Types of the protective fault supervisor
package pfs_pkg;
    typedef enum logic [4:0] {
        PFS_STOP = 5'b00001,
        PFS_CHECK = 5'b00010,
        PFS_RUN = 5'b00100,
        PFS_TRIP = 5'b01000,
        PFS_WAIT = 5'b10000
    } pfs_state_e;

    typedef struct packed {
        logic dev_reset;
        logic light_load;
        logic regen;
        logic second_supply_phase_lost;
        logic first_supply_phase_lost;
        logic in_phase_loss;
        logic out_phase_loss;
        logic out_fault;
        logic earth_fault;
        logic start_cmd;
    } pfs_pins_s;

    typedef struct packed {
        logic retry_excess_trip;
        logic input_phase_loss_trip;
        logic output_phase_loss_trip;
        logic output_fault_trip;
        logic ground_fault_trip;
    } pfs_trips_s;
endpackage

// ---- rtl/pfs_supervisor.sv ----
// Fault supervisor with start check, injection and retry
//
// Behaviour
// - Start earth check runs only when selected
// - Earth fault at check trips and shuts off
// - Start check delays output by 20 ms
// - Output fault detection enabled by select bit
// - Injected code 16..253 trips, not stored
// - Injection reads 9999; writing 9999 does nothing
// - Trip shuts off, shows code, raises alarm except during retry wait with count up to 10
// - Injected trips never enter fault history
// - Injected trip holds until device reset
// - Injection ignored while a trip is active
// - Injected trips never retried
// - Faults during an active trip change neither display nor history
// - Output phase loss trip only when selected
// - Input phase loss trips after 1 s
// - First/second phase loss shuts off, no trip
// - No input phase loss check regen, light, stopped
// - Retry resets trip, restarts, optional restart sequence
// - Retry selection 0..5 picks qualifying faults
// - Retry count limits retries, picks alarm behaviour
// - Retry waits programmed 0.1..600 s time
// - Writing 0 clears successful retry counter
// - Fault-free run of 4x wait counts success
// - Too many consecutive failures raise excess trip
`timescale 1ns/1ps
`include "pfs_defs.svh"
module pfs_supervisor #(
    parameter int unsigned GCHK_CYC = `PFS_CLK_HZ / 1000 * `PFS_GCHK_MS,
    parameter int unsigned IPL_CYC = `PFS_CLK_HZ * `PFS_IPL_S,
    parameter int unsigned TENTH_CYC = `PFS_CLK_HZ / `PFS_TENTHS_PER_S
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire pfs_pkg::pfs_pins_s pins,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output pfs_pkg::pfs_trips_s trips,
    output logic output_shutoff,
    output logic fault_alarm_output,
    output logic retry_active,
    output logic restart_seq
);
    localparam int NP = $bits(pfs_pkg::pfs_pins_s);

    logic [NP-1:0] sync1, sync2, sync3, pin_q;
    pfs_pkg::pfs_pins_s p;
    logic start_d, dreset_d;
    logic [3:0] ctrl, fail_cnt;
    logic [2:0] rsel;
    logic [7:0] rcnt, trip_code, hist, hit_code, allowed;
    logic [15:0] rwait, coast, succ_cnt, tenths, wval, succ_target;
    pfs_pkg::pfs_state_e st;
    logic trip_active, injected, pend_succ, restart_now;
    logic [31:0] tmr, ipl_cnt, pre_cnt, rd_val;
    logic wr_go, wr_ok, rd_ok, inj_go, dev_reset, hit, ipl_eval, qualify, timed;

    // Three-stage input synchronisers, accept on agreement
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    pin_q[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pins[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        pin_q[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate
    assign p = pin_q;

    // Edge history of start and reset pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_d <= 1'b0;
            dreset_d <= 1'b0;
        end else begin
            start_d <= p.start_cmd;
            dreset_d <= p.dev_reset;
        end
    end

    // Bus write decode
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    assign wval = s_axi_wdata[15:0];
    always_comb begin
        wr_ok = 1'b1;
        unique case (s_axi_awaddr)
            `PFS_A_CTRL, `PFS_A_INJ, `PFS_A_RSEL, `PFS_A_RCNT, `PFS_A_RWAIT,
            `PFS_A_RSUCC, `PFS_A_COAST, `PFS_A_STAT, `PFS_A_RESET: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // Lanes 0 and 1 must both be strobed
    function automatic logic wr_at(input logic [7:0] a);
        wr_at = wr_go && (s_axi_awaddr == a) && (s_axi_wstrb[1:0] == 2'b11);
    endfunction

    // Injection only with no trip active, 9999 inert
    assign inj_go = wr_at(`PFS_A_INJ) && !trip_active &&
        (wval >= `PFS_INJ_MIN) && (wval <= `PFS_INJ_MAX);
    assign dev_reset = (p.dev_reset && !dreset_d) || (wr_at(`PFS_A_RESET) && s_axi_wdata[0]);

    // Write channel handshake and response
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PFS_RESP_OK;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (s_axi_awready) begin // Response only after the address handshake
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `PFS_RESP_OK : `PFS_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Settings registers, out-of-range writes ignored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= `PFS_CTRL_RST;
            rsel <= `PFS_RSEL_ALL;
            rcnt <= 8'h00;
            rwait <= `PFS_RWAIT_RST;
            coast <= `PFS_IDLE_9999;
        end else begin
            if (wr_at(`PFS_A_CTRL)) begin
                ctrl <= s_axi_wdata[3:0];
            end
            if (wr_at(`PFS_A_RSEL) && wval <= 16'(`PFS_RSEL_MAX)) begin
                rsel <= wval[2:0];
            end
            if (wr_at(`PFS_A_RCNT) && ((wval <= 16'(`PFS_RCNT_SUPMAX)) ||
                ((wval >= 16'(`PFS_RCNT_OUTMIN)) && (wval <= 16'(`PFS_RCNT_OUTMAX))))) begin
                rcnt <= wval[7:0];
            end
            if (wr_at(`PFS_A_RWAIT) && wval >= `PFS_RWAIT_MIN && wval <= `PFS_RWAIT_MAX) begin
                rwait <= wval;
            end
            if (wr_at(`PFS_A_COAST)) begin
                coast <= wval;
            end
        end
    end

    // Read mux
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (s_axi_araddr)
            `PFS_A_CTRL: rd_val = {28'h0, ctrl};
            `PFS_A_INJ: rd_val = {16'h0, `PFS_IDLE_9999};
            `PFS_A_RSEL: rd_val = {29'h0, rsel};
            `PFS_A_RCNT: rd_val = {24'h0, rcnt};
            `PFS_A_RWAIT: rd_val = {16'h0, rwait};
            `PFS_A_RSUCC: rd_val = {16'h0, succ_cnt};
            `PFS_A_COAST: rd_val = {16'h0, coast};
            `PFS_A_STAT: rd_val = {4'h0, fail_cnt, hist, (trip_active ? trip_code : hist),
                5'h0, (st == pfs_pkg::PFS_WAIT), injected, trip_active};
            `PFS_A_RESET: rd_val = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PFS_RESP_OK;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arready) begin // Data only after the address handshake
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? `PFS_RESP_OK : `PFS_RESP_ERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Input phase loss window, gated by load state
    assign ipl_eval = ctrl[`PFS_B_IPL] && (st == pfs_pkg::PFS_RUN) &&
        !p.regen && !p.light_load && p.in_phase_loss;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ipl_cnt <= 32'h0000_0000;
        end else if (!ipl_eval) begin
            ipl_cnt <= 32'h0000_0000;
        end else if (ipl_cnt < IPL_CYC) begin
            ipl_cnt <= ipl_cnt + 32'h0000_0001;
        end
    end

    // Fault source selection by priority
    always_comb begin
        hit = 1'b0;
        hit_code = `PFS_CODE_NONE;
        if (st == pfs_pkg::PFS_CHECK && p.earth_fault) begin
            hit = 1'b1;
            hit_code = `PFS_CODE_GF;
        end else if (st == pfs_pkg::PFS_RUN) begin
            if (ctrl[`PFS_B_OFD] && p.out_fault) begin
                hit = 1'b1;
                hit_code = `PFS_CODE_OFD;
            end else if (ctrl[`PFS_B_OPL] && p.out_phase_loss) begin
                hit = 1'b1;
                hit_code = `PFS_CODE_OPL;
            end else if (ipl_cnt >= IPL_CYC) begin
                hit = 1'b1;
                hit_code = `PFS_CODE_IPL;
            end
        end
    end

    // Retry qualification and allowed attempts
    assign qualify = (rsel == `PFS_RSEL_ALL) || (rsel == `PFS_RSEL_WIDE);
    assign allowed = (rcnt <= `PFS_RCNT_SUPMAX) ? rcnt : 8'(rcnt - `PFS_RCNT_OFS);
    assign succ_target = 16'(rwait * 16'(`PFS_SUCC_MULT));
    assign timed = (st == pfs_pkg::PFS_WAIT) || (st == pfs_pkg::PFS_RUN && pend_succ);

    // Tenth-second timebase for wait and success
    always_ff @(posedge clk_sys) begin
        if (rst || !timed || restart_now || hit) begin
            pre_cnt <= 32'h0000_0000;
            tenths <= 16'h0000;
        end else if (pre_cnt == TENTH_CYC - 1) begin
            pre_cnt <= 32'h0000_0000;
            tenths <= tenths + 16'h0001;
        end else begin
            pre_cnt <= pre_cnt + 32'h0000_0001;
        end
    end

    // Main sequencer: start check, run, trip, retry wait
    always_ff @(posedge clk_sys) begin
        if (rst || (dev_reset && !hit && !inj_go)) begin // Trip beats a coincident reset
            st <= pfs_pkg::PFS_STOP;
            trip_active <= 1'b0;
            injected <= 1'b0;
            trip_code <= `PFS_CODE_NONE;
            fail_cnt <= 4'h0;
            pend_succ <= 1'b0;
            tmr <= 32'h0000_0000;
            restart_now <= 1'b0;
        end else begin
            restart_now <= 1'b0;
            if (inj_go) begin
                st <= pfs_pkg::PFS_TRIP;
                trip_active <= 1'b1;
                injected <= 1'b1;
                trip_code <= wval[7:0];
            end else if (hit) begin
                trip_active <= 1'b1;
                if (rcnt != 8'h00 && qualify && fail_cnt >= 4'(allowed)) begin
                    st <= pfs_pkg::PFS_TRIP;
                    trip_code <= `PFS_CODE_RET;
                    pend_succ <= 1'b0;
                end else if (rcnt != 8'h00 && qualify) begin
                    st <= pfs_pkg::PFS_WAIT;
                    trip_code <= hit_code;
                    fail_cnt <= fail_cnt + 4'h1;
                    pend_succ <= 1'b0;
                end else begin
                    st <= pfs_pkg::PFS_TRIP;
                    trip_code <= hit_code;
                end
            end else begin
                unique case (st)
                    pfs_pkg::PFS_STOP: begin
                        if (p.start_cmd && !start_d) begin
                            tmr <= 32'h0000_0000;
                            st <= ctrl[`PFS_B_GCHK] ? pfs_pkg::PFS_CHECK : pfs_pkg::PFS_RUN;
                        end
                    end
                    pfs_pkg::PFS_CHECK: begin
                        if (!p.start_cmd) begin
                            st <= pfs_pkg::PFS_STOP;
                        end else if (tmr >= GCHK_CYC - 1) begin
                            st <= pfs_pkg::PFS_RUN;
                        end else begin
                            tmr <= tmr + 32'h0000_0001;
                        end
                    end
                    pfs_pkg::PFS_RUN: begin
                        if (pend_succ && tenths >= succ_target) begin
                            pend_succ <= 1'b0;
                            fail_cnt <= 4'h0;
                        end
                        if (!p.start_cmd || p.first_supply_phase_lost || p.second_supply_phase_lost) begin
                            st <= pfs_pkg::PFS_STOP;
                        end
                    end
                    pfs_pkg::PFS_TRIP: begin
                        st <= pfs_pkg::PFS_TRIP;
                    end
                    pfs_pkg::PFS_WAIT: begin
                        if (tenths >= rwait) begin
                            st <= pfs_pkg::PFS_RUN;
                            trip_active <= 1'b0;
                            pend_succ <= 1'b1;
                            restart_now <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Fault history: first real fault of a sequence, or the retry excess code
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hist <= `PFS_CODE_NONE;
        end else if (!inj_go && hit && fail_cnt == 4'h0) begin
            hist <= hit_code;
        end else if (!inj_go && hit && rcnt != 8'h00 && qualify &&
            fail_cnt >= 4'(allowed)) begin
            hist <= `PFS_CODE_RET;
        end
    end

    // Successful retry counter, coincident clear and increment give 1
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            succ_cnt <= 16'h0000;
        end else if (!dev_reset && !inj_go && !hit && st == pfs_pkg::PFS_RUN &&
            pend_succ && tenths >= succ_target) begin
            succ_cnt <= (wr_at(`PFS_A_RSUCC) && wval == 16'h0000) ? 16'h0001 : succ_cnt + 16'h0001;
        end else if (wr_at(`PFS_A_RSUCC) && wval == 16'h0000) begin
            succ_cnt <= 16'h0000;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            output_shutoff <= 1'b1;
            fault_alarm_output <= 1'b0;
            retry_active <= 1'b0;
            restart_seq <= 1'b0;
            trips <= '0;
        end else begin
            output_shutoff <= (st != pfs_pkg::PFS_RUN) || trip_active;
            fault_alarm_output <= trip_active &&
                !(st == pfs_pkg::PFS_WAIT && rcnt <= `PFS_RCNT_SUPMAX);
            retry_active <= (st == pfs_pkg::PFS_WAIT);
            restart_seq <= restart_now && (coast != `PFS_IDLE_9999);
            trips.ground_fault_trip <= trip_active && trip_code == `PFS_CODE_GF && !injected;
            trips.output_fault_trip <= trip_active && trip_code == `PFS_CODE_OFD && !injected;
            trips.output_phase_loss_trip <= trip_active && trip_code == `PFS_CODE_OPL && !injected;
            trips.input_phase_loss_trip <= trip_active && trip_code == `PFS_CODE_IPL && !injected;
            trips.retry_excess_trip <= trip_active && trip_code == `PFS_CODE_RET && !injected;
        end
    end
endmodule // pfs_supervisor

// ---- verification/pfs_supervisor_sva.sv ----
// Port checker of the fault supervisor
`timescale 1ns/1ps
module pfs_supervisor_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pfs_pkg::pfs_trips_s trips,
    input wire logic output_shutoff,
    input wire logic fault_alarm_output,
    input wire logic retry_active,
    input wire logic restart_seq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Requests offered to an idle slave
    sequence s_wr_req;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    endsequence
    sequence s_rd_req;
        s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    endsequence
    sequence s_pulse;
        restart_seq ##1 !restart_seq;
    endsequence
    AST_RESET: assert property (disable iff (1'b0) rst |=> output_shutoff && !fault_alarm_output && trips == '0)
        else $error("outputs wrong after reset");
    AST_WR_ANSWER: assert property (s_wr_req |=> s_axi_awready ##1 s_axi_bvalid)
        else $error("write not answered");
    AST_RD_HOLD: assert property (s_rd_req |=> s_axi_arready ##1 s_axi_rvalid ##1 (s_axi_rvalid || $past(s_axi_rready)))
        else $error("read answer dropped");
    AST_TRIP_SHUT: assert property ((|trips) |-> output_shutoff)
        else $error("trip without shutoff");
    AST_TRIP_ALARM: assert property ((|trips) && !retry_active |-> fault_alarm_output)
        else $error("trip without alarm");
    AST_TRIP_KEEP: assert property ((|trips) |=> trips == $past(trips) || trips == '0)
        else $error("trip changed");
    AST_ALARM_SHUT: assert property (fault_alarm_output |-> output_shutoff)
        else $error("alarm while running");
    AST_WAIT_SHUT: assert property (retry_active |-> output_shutoff)
        else $error("running in retry wait");
    AST_RESTART_PULSE: assert property (restart_seq |-> s_pulse)
        else $error("restart pulse too long");
endmodule // pfs_supervisor_sva

bind pfs_supervisor pfs_supervisor_sva pfs_supervisor_sva_i (.clk_sys, .rst, .s_axi_awvalid, .s_axi_wvalid,
    .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .trips, .output_shutoff, .fault_alarm_output, .retry_active, .restart_seq);

// ---- verification/pfs_host_model.sv ----
// Host software model writing settings over AXI4-Lite
`timescale 1ns/1ps
module pfs_host_model (
    input wire logic clk_sys,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic hung
);
    // Idle bus
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
        s_axi_wstrb = 4'hf;
    end
    // Write: address and data together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        s_axi_bready <= 1'b0;
        if (n >= 100) hung <= 1'b1;
    endtask
    // Read: rready held until the answer
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        s_axi_rready <= 1'b0;
        if (n >= 100) hung <= 1'b1;
    endtask
endmodule // pfs_host_model

// ---- verification/test_pfs_supervisor.sv ----
// Testbench of the protective fault supervisor
`timescale 1ns/1ps
`include "pfs_defs.svh"
module test_pfs_supervisor;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    pfs_pkg::pfs_pins_s pins = '0;
    logic [7:0] s_axi_awaddr, s_axi_araddr, code;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hung;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    pfs_pkg::pfs_trips_s trips;
    logic output_shutoff, fault_alarm_output, retry_active, restart_seq;
    logic [33:0] q[$];
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 32'h5fdb4153;
    int wait_n;
    always #12.5 clk_sys = ~clk_sys;
    pfs_supervisor #(.GCHK_CYC(20), .IPL_CYC(50), .TENTH_CYC(10)) pfs_supervisor_i (.clk_sys, .rst, .pins,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trips, .output_shutoff, .fault_alarm_output, .retry_active,
        .restart_seq);
    pfs_host_model pfs_host_model_i (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .hung);
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Read with its answer noted first
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back(e);
        pfs_host_model_i.rd(a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        pfs_host_model_i.wr(a, d);
    endtask
    // Trips, shutoff and alarm together
    task automatic outs(input logic [6:0] e);
        chk("outputs", {27'h0, e}, {27'h0, trips, output_shutoff, fault_alarm_output});
    endtask
    // Device reset pin pulse with all inputs released
    task automatic dev_rst();
        pins <= '0;
        go(6);
        pins.dev_reset <= 1'b1;
        go(6);
        pins.dev_reset <= 1'b0;
        go(6);
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Read answers against the oldest note
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready) begin
            chk("read", q.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
    end
    always @(posedge hung) begin
        n_mismatch++;
        finish_test();
    end
    initial begin
        go(20);
        rst <= 1'b0;
        go(2);
        rd(`PFS_A_CTRL, 34'hc);
        rd(`PFS_A_INJ, 34'h270f);
        rd(`PFS_A_RWAIT, 34'ha);
        rd(8'h24, 34'h200000000);
        wr(`PFS_A_RSUCC, 32'h0);
        rd(`PFS_A_RSUCC, 34'h0);
        // 9999 injects nothing; a random code trips without trip bit
        wr(`PFS_A_INJ, 32'h270f);
        go(6);
        outs(7'h02);
        wr(`PFS_A_RCNT, 32'h1);
        wr(`PFS_A_RWAIT, 32'h1);
        code = 8'h10 + 8'($unsigned($random(seed)) % 238);
        wr(`PFS_A_INJ, {24'h0, code});
        go(4);
        outs(7'h03);
        wr(`PFS_A_INJ, 32'hfd);
        go(60);
        outs(7'h03);
        rd(`PFS_A_STAT, {18'h0, code, 8'h03});
        wr(`PFS_A_RESET, 32'h1);
        go(4);
        outs(7'h02);
        rd(`PFS_A_STAT, 34'h0);
        // Start check delays output; output fault follows its select
        wr(`PFS_A_RCNT, 32'h0);
        wr(`PFS_A_CTRL, 32'hd);
        pins.start_cmd <= 1'b1;
        go(12);
        outs(7'h02);
        go(30);
        pins.out_fault <= 1'b1;
        go(10);
        outs(7'h00);
        wr(`PFS_A_CTRL, 32'hf);
        go(8);
        outs(7'h0b);
        pins.out_phase_loss <= 1'b1;
        go(10);
        outs(7'h0b);
        dev_rst();
        outs(7'h02);
        // Earth fault at start, then skipped check
        pins.earth_fault <= 1'b1;
        pins.start_cmd <= 1'b1;
        go(40);
        outs(7'h07);
        dev_rst();
        wr(`PFS_A_CTRL, 32'h0);
        pins.earth_fault <= 1'b1;
        pins.start_cmd <= 1'b1;
        go(15);
        outs(7'h00);
        pins.out_phase_loss <= 1'b1;
        go(10);
        outs(7'h00);
        wr(`PFS_A_CTRL, 32'h8);
        pins.in_phase_loss <= 1'b1;
        go(30);
        outs(7'h00);
        go(40);
        outs(7'h23);
        dev_rst();
        pins.start_cmd <= 1'b1;
        go(15);
        pins.first_supply_phase_lost <= 1'b1;
        go(8);
        outs(7'h02);
        // Retry: silent wait, restart pulse, success, then excess
        dev_rst();
        wr(`PFS_A_RCNT, 32'h1);
        wr(`PFS_A_CTRL, 32'h2);
        wr(`PFS_A_COAST, 32'h0);
        pins.start_cmd <= 1'b1;
        go(10);
        pins.out_fault <= 1'b1;
        go(8);
        outs(7'h0a);
        chk("retry_active", 34'h1, {33'h0, retry_active});
        pins.out_fault <= 1'b0;
        for (wait_n = 0; wait_n < 40 && !restart_seq; wait_n++) begin
            go(1);
        end
        chk("restart_seq", 34'h1, {33'h0, restart_seq});
        if (restart_seq) begin
            go(60);
            rd(`PFS_A_RSUCC, 34'h1);
            wr(`PFS_A_RSUCC, 32'h0);
            rd(`PFS_A_RSUCC, 34'h0);
            pins.out_fault <= 1'b1;
            go(40);
            outs(7'h43);
            rd(`PFS_A_STAT, 34'h01050501);
            // Selection outside the retry group trips for good
            wr(`PFS_A_RSEL, 32'h1);
            dev_rst();
            pins.start_cmd <= 1'b1;
            pins.out_fault <= 1'b1;
            go(20);
            outs(7'h0b);
        end
        finish_test();
    end
endmodule // test_pfs_supervisor
